/* File: common/wstp_pkg.sv */
// Constants, register map and field layout of the waveform sample and temperature block
// How it works
// - Filtered current samples latched at 8 kSPS.
// - Sample capture never stalls power path.
// - Fresh samples set ready flag, status bit17.
// - Mask bit17 lets ready flag raise interrupt.
// - Mode 00: pin low ~70ns later, 10us.
// - Modes 01/10/11 put zero-cross on pin.
// - Current samples read sign-extended to 32 bits.
// - Converter words are 24-bit two's complement.
// - Codes near +-5,320,000 carried without overflow.
// - Enable bit high selects second voltage.
// - Cleared bit selects temperature on every variant.
// - Select level at reset follows reset sequence.
// - Factory offset held per phase, 8-bit signed.
// - Offset shifted left 11 before adding.
// - Gain scales by one plus gain/2^23.
// - First temperature result 1.024 s after select low.
// - Select high early means no temperature stored.
// - Temperature results read with top byte zero.
// - Temperatures feed current gain compensation.
// - Compensation active after first result, 8 kHz.
// - Config bit4 enables all high-pass filters.
package wstp_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_NS        = 40;
  localparam int unsigned SAMPLE_HZ     = 8_000;
  localparam int unsigned SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned PIN_DELAY_NS  = 70;
  localparam int unsigned PIN_DELAY_CYC = (PIN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_US      = 10;
  localparam int unsigned PULSE_CYC     = PULSE_US * 1000 / CLK_NS;
  localparam int unsigned SETTLE_MS     = 1024;
  localparam int unsigned SETTLE_CYC    = SETTLE_MS * (CLK_HZ / 1000);

  localparam logic [15:0] ADDR_STAT_LO  = 16'hE502;
  localparam logic [15:0] ADDR_MASK_LO  = 16'hE50A;
  localparam logic [15:0] ADDR_CFG      = 16'hE618;
  localparam logic [15:0] ADDR_CFG3     = 16'hE708;
  localparam logic [15:0] ADDR_CUR_BASE = 16'hE900;
  localparam logic [15:0] ADDR_TOS_BASE = 16'hE910;
  localparam logic [15:0] ADDR_TGN_BASE = 16'hE920;
  localparam logic [15:0] ADDR_TMP_BASE = 16'hE930;

  localparam int unsigned READY_BIT     = 17;
  localparam int unsigned HPF_BIT       = 4;
  localparam logic [1:0]  PIN_MODE_RDY  = 2'h0;
  localparam logic [15:0] CFG_RST       = 16'h0010;
  localparam logic [7:0]  CFG3_RST      = 8'h0F;
  localparam int unsigned OFFSET_SHIFT  = 11;
  localparam int unsigned GAIN_FRAC     = 23;
  localparam int unsigned HPF_SHIFT     = 8;
endpackage

/* File: rtl/wstp_capture.sv */
// Current waveform capture, ready signalling and per-phase temperature path
`timescale 1ns/1ns
module wstp_capture #(
  parameter int unsigned N_CH          = 4,
  parameter int unsigned SAMPLE_W      = 24,
  parameter int unsigned SETTLE_CYCLES = wstp_pkg::SETTLE_CYC
) (
  input  wire logic                               i_clock,        // System clock, 25 MHz
  input  wire logic                               i_rst,          // Sync reset, active high
  input  wire logic [N_CH-1:0][SAMPLE_W-1:0]      i_cur_adc,      // Current converter words
  input  wire logic [N_CH-1:0][SAMPLE_W-1:0]      i_v2t_adc,      // Second voltage / temp words
  input  wire logic [N_CH-1:0][7:0]               i_tos,          // Factory offset from link
  input  wire logic [N_CH-1:0]                    i_tos_valid,    // Offset word strobe
  input  wire logic                               i_zero_cross,   // Zero-cross level for pin
  input  wire logic [15:0]                        i_reg_addr,     // Register address
  input  wire logic                               i_reg_wr,       // Write strobe
  input  wire logic [31:0]                        i_reg_wdata,    // Write data
  input  wire logic                               i_reg_rd,       // Read strobe
  output logic      [31:0]                        o_reg_rdata,    // Read data
  output logic                                    o_reg_rvalid,   // Read data valid
  output logic                                    o_irq,          // Interrupt, active high
  output logic                                    o_zero_cross_or_ready_pin, // Shared pin
  output logic      [N_CH-1:0]                    o_sensor_select,// Per-phase select outputs
  output logic      [N_CH-1:0][SAMPLE_W-1:0]      o_hp_current,   // Filtered current to DSP
  output logic      [N_CH-1:0][SAMPLE_W-1:0]      o_comp_temp,    // Temperature to compensation
  output logic      [N_CH-1:0]                    o_comp_active   // Compensation running
);
  localparam int unsigned DIV_W = $clog2(wstp_pkg::SAMPLE_DIV);
  localparam int unsigned PIN_W = $clog2(wstp_pkg::PIN_DELAY_CYC + wstp_pkg::PULSE_CYC + 1);
  localparam int unsigned SET_W = $clog2(SETTLE_CYCLES + 1);
  localparam int unsigned EXT_W = SAMPLE_W + 3;
  localparam int unsigned ACC_W = SAMPLE_W + wstp_pkg::HPF_SHIFT;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(wstp_pkg::SAMPLE_DIV - 1);
  localparam logic [PIN_W-1:0] PIN_LOAD =
    PIN_W'(wstp_pkg::PIN_DELAY_CYC + wstp_pkg::PULSE_CYC - 1);
  localparam logic [PIN_W-1:0] PIN_LOW  = PIN_W'(wstp_pkg::PULSE_CYC);
  localparam logic [SET_W-1:0] SET_LAST = SET_W'(SETTLE_CYCLES);

  if (N_CH < 1 || N_CH > 4 || SAMPLE_W < 20 || SAMPLE_W > 28 || SETTLE_CYCLES < 1) begin : g_param_check
    $error("wstp_capture: unsupported parameter values");
  end

  // Saturate a widened signed value back to the sample width
  function automatic logic [SAMPLE_W-1:0] sat(input logic signed [EXT_W-1:0] v);
    logic signed [EXT_W-1:0] hi;
    logic signed [EXT_W-1:0] lo;
    hi = EXT_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    lo = -hi - EXT_W'(1);
    if (v > hi) begin
      sat = hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      sat = lo[SAMPLE_W-1:0];
    end else begin
      sat = v[SAMPLE_W-1:0];
    end
  endfunction

  logic [DIV_W-1:0]                 div_reg;
  logic                             strobe_reg;
  logic [15:0]                      cfg_reg;
  logic [7:0]                       cfg3_reg;
  logic                             ready_reg;
  logic                             mask_reg;
  logic [PIN_W-1:0]                 pin_cnt_reg;
  logic [N_CH-1:0][SAMPLE_W-1:0]    cur_reg;
  logic [N_CH-1:0][7:0]             tos_reg;
  logic [N_CH-1:0][SAMPLE_W-1:0]    tgain_reg;
  logic [N_CH-1:0][SAMPLE_W-1:0]    hp_next;
  logic [N_CH-1:0][SAMPLE_W-1:0]    temp_next;
  logic [N_CH-1:0]                  settled;
  logic                             hpf_on;
  logic                             ready_clr;
  logic                             pin_mode_rdy;

  assign hpf_on       = cfg_reg[wstp_pkg::HPF_BIT];
  assign pin_mode_rdy = (cfg_reg[1:0] == wstp_pkg::PIN_MODE_RDY);
  assign ready_clr    = i_reg_wr && (i_reg_addr == wstp_pkg::ADDR_STAT_LO)
                        && i_reg_wdata[wstp_pkg::READY_BIT];

  // Free divider: single strobe drives every capture and temperature store
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_reg    <= '0;
      strobe_reg <= 1'b0;
    end else begin
      div_reg    <= (div_reg == DIV_LAST) ? '0 : div_reg + DIV_W'(1);
      strobe_reg <= (div_reg == DIV_LAST);
    end
  end

  // Configuration writes; select bits reset high, matching the remote reset level
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg_reg  <= wstp_pkg::CFG_RST;
      cfg3_reg <= wstp_pkg::CFG3_RST;
      mask_reg <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == wstp_pkg::ADDR_CFG) begin
        cfg_reg <= i_reg_wdata[15:0];
      end
      if (i_reg_addr == wstp_pkg::ADDR_CFG3) begin
        cfg3_reg <= i_reg_wdata[7:0];
      end
      if (i_reg_addr == wstp_pkg::ADDR_MASK_LO) begin
        mask_reg <= i_reg_wdata[wstp_pkg::READY_BIT];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sensor_select <= '1;
    end else begin
      o_sensor_select <= cfg3_reg[N_CH-1:0];
    end
  end

  // Set wins over a same-cycle write-one-clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ready_reg <= 1'b0;
    end else if (strobe_reg) begin
      ready_reg <= 1'b1;
    end else if (ready_clr) begin
      ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= ready_reg && mask_reg;
    end
  end

  // Pin counter loads with the flag; low window is the last PULSE_CYC counts
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_cnt_reg <= '0;
    end else if (strobe_reg) begin
      pin_cnt_reg <= PIN_LOAD;
    end else if (pin_cnt_reg != '0) begin
      pin_cnt_reg <= pin_cnt_reg - PIN_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_zero_cross_or_ready_pin <= 1'b1;
    end else if (pin_mode_rdy) begin
      o_zero_cross_or_ready_pin <= !(pin_cnt_reg != '0 && pin_cnt_reg <= PIN_LOW);
    end else begin
      o_zero_cross_or_ready_pin <= i_zero_cross;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < N_CH; ch++) begin : g_ch
      logic signed [ACC_W-1:0]   dc_reg;
      logic signed [ACC_W:0]     dc_err;
      logic signed [EXT_W-1:0]   hp_diff;
      logic signed [EXT_W-1:0]   t_sum;
      logic signed [2*EXT_W-1:0] t_prod;
      logic signed [EXT_W-1:0]   t_scaled;
      logic [SET_W-1:0]          settle_reg;

      // Slow dc tracker; saturating subtract keeps full-scale codes intact
      assign dc_err  = (ACC_W+1)'($signed({i_cur_adc[ch], {wstp_pkg::HPF_SHIFT{1'b0}}}))
                       - (ACC_W+1)'(dc_reg);
      assign hp_diff = EXT_W'($signed(i_cur_adc[ch]))
                       - EXT_W'($signed(dc_reg[ACC_W-1:wstp_pkg::HPF_SHIFT]));
      assign hp_next[ch] = hpf_on ? sat(hp_diff) : i_cur_adc[ch];

      always_ff @(posedge i_clock) begin
        if (i_rst || !hpf_on) begin
          dc_reg <= '0;
        end else if (strobe_reg) begin
          dc_reg <= dc_reg + ACC_W'(dc_err >>> wstp_pkg::HPF_SHIFT);
        end
      end

      // Offset is shifted up then added; gain is a Q23 correction on top
      assign t_sum    = EXT_W'($signed(i_v2t_adc[ch]))
                        + (EXT_W'($signed(tos_reg[ch])) <<< wstp_pkg::OFFSET_SHIFT);
      assign t_prod   = (2*EXT_W)'(t_sum) * (2*EXT_W)'($signed(tgain_reg[ch]));
      assign t_scaled = t_sum + EXT_W'(t_prod >>> wstp_pkg::GAIN_FRAC);
      assign temp_next[ch] = sat(t_scaled);

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          tos_reg[ch] <= '0;
        end else if (i_tos_valid[ch]) begin
          tos_reg[ch] <= i_tos[ch];
        end
      end

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          tgain_reg[ch] <= '0;
        end else if (i_reg_wr && i_reg_addr == wstp_pkg::ADDR_TGN_BASE + 16'(ch)) begin
          tgain_reg[ch] <= i_reg_wdata[SAMPLE_W-1:0];
        end
      end

      // Settle timer restarts whenever the select line goes back high
      always_ff @(posedge i_clock) begin
        if (i_rst || o_sensor_select[ch]) begin
          settle_reg <= '0;
        end else if (settle_reg != SET_LAST) begin
          settle_reg <= settle_reg + SET_W'(1);
        end
      end
      assign settled[ch] = (settle_reg == SET_LAST) && !o_sensor_select[ch];

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          o_comp_temp[ch]   <= '0;
          o_comp_active[ch] <= 1'b0;
        end else if (o_sensor_select[ch]) begin
          o_comp_active[ch] <= 1'b0;
        end else if (strobe_reg && settled[ch]) begin
          o_comp_temp[ch]   <= temp_next[ch];
          o_comp_active[ch] <= 1'b1;
        end
      end
    end
  endgenerate

  // Power path sees every filtered word; capture is a side copy
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_hp_current <= '0;
    end else begin
      o_hp_current <= hp_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cur_reg <= '0;
    end else if (strobe_reg) begin
      cur_reg <= hp_next;
    end
  end

  // Register read port, one cycle latency, unmapped reads return zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_reg_rdata  <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_rdata  <= '0;
      if (i_reg_rd) begin
        case (i_reg_addr)
          wstp_pkg::ADDR_STAT_LO: o_reg_rdata[wstp_pkg::READY_BIT] <= ready_reg;
          wstp_pkg::ADDR_MASK_LO: o_reg_rdata[wstp_pkg::READY_BIT] <= mask_reg;
          wstp_pkg::ADDR_CFG:     o_reg_rdata[15:0] <= cfg_reg;
          wstp_pkg::ADDR_CFG3:    o_reg_rdata[7:0]  <= cfg3_reg;
          default: begin
            for (int i = 0; i < N_CH; i++) begin
              if (i_reg_addr == wstp_pkg::ADDR_CUR_BASE + 16'(i)) begin
                o_reg_rdata <= 32'($signed(cur_reg[i]));
              end
              if (i_reg_addr == wstp_pkg::ADDR_TOS_BASE + 16'(i)) begin
                o_reg_rdata <= 32'($signed(tos_reg[i]));
              end
              if (i_reg_addr == wstp_pkg::ADDR_TGN_BASE + 16'(i)) begin
                o_reg_rdata <= 32'($signed(tgain_reg[i]));
              end
              if (i_reg_addr == wstp_pkg::ADDR_TMP_BASE + 16'(i)) begin
                o_reg_rdata <= {8'h00, 24'(o_comp_temp[i])};
              end
            end
          end
        endcase
      end
    end
  end

  // Helper state for checks
  logic [PIN_W-1:0] low_run_reg;
  logic             rd_temp_reg;
  logic             rd_cur_reg;
  logic             cur_sign_reg;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      low_run_reg  <= '0;
      rd_temp_reg  <= 1'b0;
      rd_cur_reg   <= 1'b0;
      cur_sign_reg <= 1'b0;
    end else begin
      low_run_reg  <= o_zero_cross_or_ready_pin ? '0 : low_run_reg + PIN_W'(1);
      rd_temp_reg  <= i_reg_rd && i_reg_addr == wstp_pkg::ADDR_TMP_BASE;
      rd_cur_reg   <= i_reg_rd && i_reg_addr == wstp_pkg::ADDR_CUR_BASE;
      cur_sign_reg <= cur_reg[0][SAMPLE_W-1];
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_capture;
    strobe_reg ##1 ready_reg;
  endsequence
  sequence s_pin_fall;
    o_zero_cross_or_ready_pin ##1 !o_zero_cross_or_ready_pin;
  endsequence

  property p_strobe_gap;
    strobe_reg |=> !strobe_reg [*8];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe repeated too soon");

  property p_ready_set;
    strobe_reg |-> s_capture;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_ready_hold;
    ready_reg && !ready_clr |=> ready_reg;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready flag lost");

  property p_irq;
    ##1 (o_irq == ($past(ready_reg) && $past(mask_reg)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not flag and mask");

  property p_pin_fall;
    strobe_reg && pin_mode_rdy ##1 pin_mode_rdy [*2] |=> !o_zero_cross_or_ready_pin;
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("ready pin late");

  property p_pin_width;
    pin_mode_rdy && $past(pin_mode_rdy) && $rose(o_zero_cross_or_ready_pin)
      |-> low_run_reg == PIN_LOW;
  endproperty
  a_pin_width: assert property (p_pin_width) else $error("ready pulse width wrong");

  property p_pin_zx;
    !pin_mode_rdy |=> o_zero_cross_or_ready_pin == $past(i_zero_cross);
  endproperty
  a_pin_zx: assert property (p_pin_zx) else $error("zero-cross not on pin");

  property p_select;
    i_reg_wr && i_reg_addr == wstp_pkg::ADDR_CFG3 |-> ##2
      o_sensor_select == $past(i_reg_wdata[N_CH-1:0], 2);
  endproperty
  a_select: assert property (p_select) else $error("select pins not following config");

  property p_cur_stable;
    !strobe_reg |=> $stable(cur_reg);
  endproperty
  a_cur_stable: assert property (p_cur_stable) else $error("sample changed off strobe");

  property p_no_temp_high;
    o_sensor_select[0] |=> $stable(o_comp_temp[0]) && !o_comp_active[0];
  endproperty
  a_no_temp_high: assert property (p_no_temp_high) else $error("temperature stored early");

  property p_temp_pad;
    rd_temp_reg |-> o_reg_rvalid && o_reg_rdata[31:24] == 8'h00;
  endproperty
  a_temp_pad: assert property (p_temp_pad) else $error("temperature top byte not zero");

  property p_cur_sext;
    rd_cur_reg && $stable(cur_reg) |-> o_reg_rdata[31:24] == {8{cur_sign_reg}};
  endproperty
  a_cur_sext: assert property (p_cur_sext) else $error("sample not sign extended");
endmodule

/* File: tb/wstp_conv_model.sv */
// Behavioural model of the four isolated converters and their offset link
`timescale 1ns/1ns
module wstp_conv_model #(
  parameter logic [23:0] CUR_BASE  = 24'hAED2C0,
  parameter logic [23:0] V2_WORD   = 24'h123456,
  parameter logic [23:0] TEMP_WORD = 24'hF00000,
  parameter logic [7:0]  TOS_WORD  = 8'hF0
) (
  input  wire logic             i_clock,    // System clock
  input  wire logic             i_rst,      // Sync reset
  input  wire logic [3:0]       i_select,   // Per-phase select level
  output logic      [3:0][23:0] o_cur_adc,  // Current words
  output logic      [3:0][23:0] o_v2t_adc,  // Second voltage or temperature words
  output logic      [3:0][7:0]  o_tos,      // Factory offset word
  output logic      [3:0]       o_tos_valid // Offset strobe
);
  logic [3:0] cnt_reg;
  always_comb begin
    for (int ch = 0; ch < 4; ch++) begin
      o_cur_adc[ch] = CUR_BASE + 24'(ch);
      o_v2t_adc[ch] = i_select[ch] ? V2_WORD : TEMP_WORD;
      // Stale link word shows inverted outside its strobe
      o_tos[ch]     = (cnt_reg == 4'h4) ? TOS_WORD : ~TOS_WORD;
    end
  end
  // Offset sent once after reset, as the link does at start-up
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hF) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign o_tos_valid = {4{cnt_reg == 4'h4}};
endmodule

/* File: tb/wstp_capture_test.sv */
// Self-checking bench for the waveform capture and temperature block
`timescale 1ns/1ns
module wstp_capture_test;
  localparam int unsigned SETTLE = 4000;
  localparam logic [23:0] CUR    = 24'hAED2C0;
  localparam logic [23:0] TMPW   = 24'hF00000;
  logic             i_clock;
  logic             i_rst;
  logic             i_zero_cross;
  logic             i_reg_wr;
  logic             i_reg_rd;
  logic [15:0]      i_reg_addr;
  logic [31:0]      i_reg_wdata;
  logic [31:0]      o_reg_rdata;
  logic             o_reg_rvalid;
  logic             o_irq;
  logic             o_pin;
  logic [3:0][23:0] cur;
  logic [3:0][23:0] v2t;
  logic [3:0][23:0] hp;
  logic [3:0][23:0] temp_result_c;
  logic [3:0][7:0]  tos;
  logic [3:0]       tos_v;
  logic [3:0]       sel;
  logic [3:0]       act;
  int               n_mismatch = 0;
  int               total_checks = 0;

  wstp_capture #(.SETTLE_CYCLES(SETTLE)) wstp_capture_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_cur_adc(cur), .i_v2t_adc(v2t), .i_tos(tos), .i_tos_valid(tos_v),
    .i_zero_cross(i_zero_cross), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .o_irq(o_irq), .o_zero_cross_or_ready_pin(o_pin),
    .o_sensor_select(sel), .o_hp_current(hp), .o_comp_temp(temp_result_c), .o_comp_active(act));
  wstp_conv_model #(.CUR_BASE(CUR), .TEMP_WORD(TMPW)) wstp_conv_model_inst (.i_clock(i_clock),
    .i_rst(i_rst), .i_select(sel), .o_cur_adc(cur), .o_v2t_adc(v2t), .o_tos(tos),
    .o_tos_valid(tos_v));

  always #20 i_clock = ~i_clock;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge i_clock);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask
  // Read data stands only in the cycle after the read edge
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge i_clock);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clock);
    chk("read valid", 32'h1, {31'h0, o_reg_rvalid});
    d = o_reg_rdata;
    i_reg_rd = 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, exp, d);
  endtask
  // Bounded wait for the ready pulse, then measure its low time
  task automatic wait_fall(output int low, output logic irq_at);
    int k;
    k = 0;
    low = 0;
    while (o_pin !== 1'b0 && k < 4000) begin
      @(negedge i_clock);
      k++;
    end
    chk("pin fell", 32'h0, {31'h0, o_pin});
    irq_at = o_irq;
    while (o_pin === 1'b0 && low < 400) begin
      @(negedge i_clock);
      low++;
    end
  endtask
  function automatic logic [31:0] exp_temp(input logic signed [23:0] w,
                                           input logic signed [7:0] os,
                                           input logic signed [23:0] g);
    logic signed [47:0] t;
    t = 48'(w) + (48'(os) <<< 11);
    t = t + ((t * 48'(g)) >>> 23);
    return {8'h00, t[23:0]};
  endfunction

  task automatic t_reset;
    chk("select", 32'hF, {28'h0, sel});
    chk("pin idle", 32'h1, {31'h0, o_pin});
    chk("irq", 32'h0, {31'h0, o_irq});
    rdchk(wstp_pkg::ADDR_CFG3, 32'h0000000F, "cfg3");
    rdchk(wstp_pkg::ADDR_CFG, 32'h00000010, "cfg");
    rdchk(wstp_pkg::ADDR_MASK_LO, 32'h0, "mask");
    rdchk(16'hE7FF, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_samples;
    int low;
    logic irq_at;
    logic [31:0] d;
    wr(wstp_pkg::ADDR_CFG, 32'h0);
    wr(wstp_pkg::ADDR_MASK_LO, 32'h00020000);
    wait_fall(low, irq_at);
    wait_fall(low, irq_at);
    chk("pin low cycles", 32'(wstp_pkg::PULSE_CYC), 32'(low));
    chk("irq on ready", 32'h1, {31'h0, irq_at});
    // Burst of sample reads started by the pin's rising edge
    for (int ch = 0; ch < 4; ch++) begin
      rdchk(wstp_pkg::ADDR_CUR_BASE + 16'(ch), {8'hFF, CUR + 24'(ch)}, "sample");
    end
    chk("hp path", {8'h0, CUR}, {8'h0, hp[0]});
    rdchk(wstp_pkg::ADDR_STAT_LO, 32'h00020000, "status");
    wr(wstp_pkg::ADDR_STAT_LO, 32'h0);
    rdchk(wstp_pkg::ADDR_STAT_LO, 32'h00020000, "status kept");
    wr(wstp_pkg::ADDR_STAT_LO, 32'h00020000);
    cyc(2);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    rdchk(wstp_pkg::ADDR_STAT_LO, 32'h0, "status cleared");
    wr(wstp_pkg::ADDR_MASK_LO, 32'h0);
    wait_fall(low, irq_at);
    chk("irq masked", 32'h0, {31'h0, irq_at});
    wr(wstp_pkg::ADDR_CFG, 32'h10);
    repeat (3) wait_fall(low, irq_at);
    rd(wstp_pkg::ADDR_CUR_BASE, d);
    total_checks++;
    // Dc input must shrink once the filter runs
    if (($signed(d) > $signed({8'hFF, CUR})) !== 1'b1) begin
      n_mismatch++;
      $display("wrong value hpf sample expected above %h seen %h", {8'hFF, CUR}, d);
    end
    $display("test samples done");
  endtask
  task automatic t_pin_modes;
    for (int m = 1; m < 4; m++) begin
      wr(wstp_pkg::ADDR_CFG, 32'(m));
      i_zero_cross = 1'b0;
      cyc(2);
      chk("zx pin low", 32'h0, {31'h0, o_pin});
      i_zero_cross = 1'b1;
      cyc(2);
      chk("zx pin high", 32'h1, {31'h0, o_pin});
    end
    wr(wstp_pkg::ADDR_CFG, 32'h0);
    $display("test pin modes done");
  endtask
  task automatic t_temp;
    int low;
    int k;
    logic irq_at;
    logic [31:0] e;
    wr(wstp_pkg::ADDR_CFG3, 32'h0D);
    cyc(2);
    chk("select b low", 32'hD, {28'h0, sel});
    // A strobe passes while b is low for less than the settle time
    wait_fall(low, irq_at);
    chk("no early result", 32'h0, {28'h0, act});
    wr(wstp_pkg::ADDR_CFG3, 32'h0F);
    rdchk(wstp_pkg::ADDR_TMP_BASE + 16'h1, 32'h0, "temp b");
    wr(wstp_pkg::ADDR_TGN_BASE, 32'h00400000);
    rdchk(wstp_pkg::ADDR_TGN_BASE, 32'h00400000, "gain a");
    wr(wstp_pkg::ADDR_TOS_BASE, 32'h0);
    rdchk(wstp_pkg::ADDR_TOS_BASE, 32'hFFFFFFF0, "offset a");
    wr(wstp_pkg::ADDR_CFG3, 32'h0E);
    k = 0;
    while (act[0] !== 1'b1 && k < 8000) begin
      @(negedge i_clock);
      k++;
    end
    chk("settled", 32'h1, {31'h0, k >= SETTLE});
    chk("active", 32'h1, {28'h0, act});
    e = exp_temp(TMPW, 8'hF0, 24'h400000);
    rdchk(wstp_pkg::ADDR_TMP_BASE, e, "temp a");
    chk("comp temp", e, {8'h0, temp_result_c[0]});
    wr(wstp_pkg::ADDR_CFG3, 32'h0F);
    $display("test temperature done");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Run takes about nine sample periods; allow over twice that
  initial begin
    repeat (70000) @(posedge i_clock);
    n_mismatch++;
    summarize();
  end
  initial begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    i_zero_cross = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 16'h0;
    i_reg_wdata = 32'h0;
    repeat (5) @(negedge i_clock);
    i_rst = 1'b0;
    t_reset();
    t_samples();
    t_pin_modes();
    t_temp();
    summarize();
  end
endmodule
